// ---- hdl/mswle_pkg.sv ----
// constants and types shared by the slave function handler
package mswle_pkg;
  // function and exception codes
  localparam logic [7:0] FN_WRITE_MULTI = 8'h10;
  localparam logic [7:0] FN_ACCESS_LOG = 8'h46;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_DATA = 8'h03;
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  // frame layout, byte positions within a query
  localparam logic [8:0] POS_SLAVE = 9'h000;
  localparam logic [8:0] POS_FUNC = 9'h001;
  localparam logic [8:0] POS_START_HI = 9'h002;
  localparam logic [8:0] POS_START_LO = 9'h003;
  localparam logic [8:0] POS_COUNT_HI = 9'h004;
  localparam logic [8:0] POS_COUNT_LO = 9'h005;
  localparam logic [8:0] POS_BYTES = 9'h006;
  localparam logic [8:0] POS_DATA = 9'h007;
  localparam logic [8:0] CNT_MAX = 9'h1ff;
  // seven header bytes plus two check bytes
  localparam logic [8:0] WR_FIXED_LEN = 9'h009;
  localparam logic [8:0] MIN_FRAME_LEN = 9'h004;
  localparam logic [8:0] LOG_FRAME_LEN = 9'h004;
  localparam logic [15:0] MAX_REGS = 16'h007d;
  localparam logic [6:0] MAX_WORDS = 7'h7d;
  // response payload lengths, check bytes excluded
  localparam logic [2:0] RSP_LEN_EXC = 3'h3;
  localparam logic [2:0] RSP_LEN_FULL = 3'h6;
  // frame check
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;
  // handler states, one-hot
  typedef enum logic [3:0] {
    ST_RX = 4'h1,
    ST_SCAN = 4'h2,
    ST_WRITE = 4'h4,
    ST_TX = 4'h8
  } mswle_state_e;
endpackage

// ---- hdl/mswle_crc16.sv ----
// one byte step of the reflected frame check
`timescale 1ns/10ps
module mswle_crc16
  import mswle_pkg::*;
(
  // running value and byte
  input wire logic [15:0] crc_in,
  input wire logic [7:0] data_in,
  // updated value
  output logic [15:0] crc_out
);

  // lsb first, shift right with conditional polynomial
  always_comb begin
    logic [15:0] c;
    c = crc_in ^ {8'h00, data_in};
    for (int i = 0; i < 8; i++) begin
      if (c[0]) begin
        c = (c >> 1) ^ CRC_POLY;
      end else begin
        c = c >> 1;
      end
    end
    crc_out = c;
  end

endmodule

// ---- hdl/mswle_top.sv ----
// slave handler for write-multiple, access-log and exception replies
`timescale 1ns/10ps
// Function
// R1: write query is addr, func 10, start, count, byte count, data, crc lo/hi
// R2: start field is register number minus 40001
// R3: master asks at most 125 registers per write query
// R4: byte count equals twice the count, range 02 to FA
// R5: each word high byte first, words in ascending register order
// R6: write reply echoes addr, function, start and count with new crc
// R7: slave address zero in a write query is a broadcast, still executed
// R8: log query returns start and count of last successful read or write
// R9: log holds zero after any other function
// R10: log query never broadcast, holds only addr, function and crc
// R11: log reply carries addr, function, 16-bit start, 16-bit count, crc
// R12: unhandled function, address or data gets an exception reply
// R13: bad parity, crc, overrun, framing or busy frames get no reply
// R14: no reply of any kind to a broadcast
// R15: exception reply is addr, function plus 80, code, crc lo/hi
// R16: unsupported function gives code 01
// R17: unusable register address gives code 02
// R18: unacceptable data gives code 03
// R19: partly accessible range is no address error, bad registers skipped
// R20: address error when no register in range exists
// R21: writes to missing registers are discarded
// R22: frame check is crc-16, polynomial a001 reflected, start ffff
// R23: frames for other slave addresses are ignored silently
module mswle_top
  import mswle_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // own station address
  input wire logic [7:0] my_addr,
  // received bytes from the character receiver
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_end,
  input wire logic rx_err,
  // holding register access port
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  input wire logic reg_present,
  input wire logic reg_writable,
  input wire logic reg_value_ok,
  // reply bytes to the transmitter
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready
);

  typedef struct packed {
    mswle_state_e st;
    logic [8:0] cnt;
    logic dirty;
    logic [7:0] slv;
    logic [7:0] fn;
    logic [15:0] sa;
    logic [15:0] nreg;
    logic [7:0] bc;
    logic [7:0] hold;
    logic [15:0] crc;
    logic [6:0] idx;
    logic [15:0] raddr;
    logic [15:0] rdata;
    logic any_ok;
    logic bad;
    logic [15:0] log_a;
    logic [15:0] log_n;
    logic [5:0][7:0] tb;
    logic [2:0] tlen;
    logic [2:0] ti;
    logic [7:0] tx_data;
  } mswle_state_s;

  mswle_state_s s, next_s;
  logic [15:0] mem [MAX_WORDS];
  logic mem_we;
  logic [6:0] mem_wa;
  logic [15:0] mem_wd;
  logic [15:0] crc_step;
  logic [8:0] dpos;
  logic frame_ok, addr_hit, acc_ok, last_idx, wr_fmt_ok;

  // one crc stepper serves reception and transmission, never both at once
  mswle_crc16 u_crc (
    .crc_in(s.crc),
    .data_in(s.st == ST_TX ? s.tx_data : rx_data),
    .crc_out(crc_step)
  );

  // arm the transmitter with the first payload byte
  function automatic mswle_state_s start_tx(mswle_state_s c,
                                            logic [2:0] len);
    mswle_state_s r;
    r = c;
    r.tlen = len;
    r.ti = '0;
    r.crc = CRC_INIT;
    r.tx_data = c.tb[0];
    r.st = ST_TX;
    return r;
  endfunction

  // exception reply, suppressed for broadcast; log falls back to zero
  function automatic mswle_state_s load_exc(mswle_state_s c,
                                            logic [7:0] code);
    mswle_state_s r;
    r = c;
    r.log_a = '0; // see R9
    r.log_n = '0;
    r.st = ST_RX;
    if (c.slv != BCAST_ADDR) begin // see R14
      r.tb[0] = c.slv; // see R15
      r.tb[1] = c.fn | EXC_FLAG;
      r.tb[2] = code;
      r = start_tx(r, RSP_LEN_EXC);
    end
    return r;
  endfunction

  // frame qualification; check bytes included so a clean frame leaves zero
  assign frame_ok = !rx_err && (s.cnt >= MIN_FRAME_LEN)
                    && (s.crc == CRC_RESIDUE); // see R13, R22
  assign addr_hit = (s.slv == my_addr) || (s.slv == BCAST_ADDR); // see R23
  assign acc_ok = reg_present && reg_writable; // see R21
  assign last_idx = ({9'h000, s.idx} == s.nreg - 16'h0001);
  assign wr_fmt_ok = (s.nreg != 16'h0000) && (s.nreg <= MAX_REGS)
                     && ({s.nreg[14:0], 1'b0} == {8'h00, s.bc})
                     && (s.cnt == {1'b0, s.bc} + WR_FIXED_LEN);
  assign dpos = s.cnt - POS_DATA;

  // outputs: data from flops, tx_valid from state, reg_wr from state and the access check
  assign reg_addr = s.raddr;
  assign reg_wdata = s.rdata;
  assign reg_wr = (s.st == ST_WRITE) && acc_ok; // see R19
  assign tx_data = s.tx_data;
  assign tx_valid = (s.st == ST_TX);

  // next state of the whole handler
  always_comb begin
    next_s = s;
    mem_we = 1'b0;
    mem_wa = dpos[7:1];
    mem_wd = {s.hold, rx_data};
    case (s.st)
      ST_RX: begin
        if (s.dirty) begin
          // tail of a frame that began while busy: drop it whole
          if (rx_end) begin // see R13
            next_s.dirty = 1'b0;
          end
        end else if (rx_end) begin
          next_s.cnt = '0;
          next_s.crc = CRC_INIT;
          if (frame_ok && addr_hit) begin
            case (s.fn)
              FN_WRITE_MULTI: begin
                if (wr_fmt_ok) begin // see R3, R4
                  next_s.st = ST_SCAN;
                  next_s.idx = '0;
                  next_s.raddr = s.sa; // see R2
                  next_s.rdata = mem[0];
                  next_s.any_ok = 1'b0;
                  next_s.bad = 1'b0;
                end else begin
                  next_s = load_exc(next_s, EXC_DATA); // see R18
                end
              end
              FN_ACCESS_LOG: begin
                next_s.log_a = '0; // see R9
                next_s.log_n = '0;
                if (s.slv == BCAST_ADDR) begin // see R10
                  next_s.st = ST_RX;
                end else if (s.cnt != LOG_FRAME_LEN) begin
                  next_s = load_exc(next_s, EXC_DATA); // see R12
                end else begin
                  next_s.tb = {s.log_n[7:0], s.log_n[15:8], s.log_a[7:0],
                               s.log_a[15:8], s.fn, s.slv}; // see R8, R11
                  next_s = start_tx(next_s, RSP_LEN_FULL);
                end
              end
              default: begin
                next_s = load_exc(next_s, EXC_FUNC); // see R16
              end
            endcase
          end
        end else if (rx_valid) begin
          next_s.crc = crc_step; // see R22
          if (s.cnt != CNT_MAX) begin
            next_s.cnt = s.cnt + 9'h001;
          end
          // field capture in the order the query carries them
          case (s.cnt) // see R1
            POS_SLAVE: next_s.slv = rx_data;
            POS_FUNC: next_s.fn = rx_data;
            POS_START_HI: next_s.sa[15:8] = rx_data;
            POS_START_LO: next_s.sa[7:0] = rx_data;
            POS_COUNT_HI: next_s.nreg[15:8] = rx_data;
            POS_COUNT_LO: next_s.nreg[7:0] = rx_data;
            POS_BYTES: next_s.bc = rx_data;
            default: begin
              // high byte held, word stored on its low byte
              if (!dpos[8] && dpos[7:1] < MAX_WORDS) begin // see R5
                if (dpos[0]) begin
                  mem_we = 1'b1;
                end else begin
                  next_s.hold = rx_data;
                end
              end
            end
          endcase
        end
      end
      ST_SCAN: begin
        // first pass only checks, so a refused value writes nothing
        next_s.any_ok = s.any_ok || acc_ok;
        next_s.bad = s.bad || (acc_ok && !reg_value_ok);
        if (last_idx) begin
          if (!next_s.any_ok) begin
            next_s = load_exc(next_s, EXC_ADDR); // see R17, R20
          end else if (next_s.bad) begin
            next_s = load_exc(next_s, EXC_DATA); // see R18
          end else begin
            next_s.st = ST_WRITE;
            next_s.idx = '0;
            next_s.raddr = s.sa;
            next_s.rdata = mem[0];
            next_s.log_a = '0;
            next_s.log_n = '0;
          end
        end else begin
          next_s.idx = s.idx + 7'h01;
          next_s.raddr = s.raddr + 16'h0001;
          next_s.rdata = mem[s.idx + 7'h01];
        end
      end
      ST_WRITE: begin
        // skipped registers neither count nor move the logged start
        if (acc_ok) begin // see R19
          if (s.log_n == 16'h0000) begin
            next_s.log_a = s.raddr; // see R8
          end
          next_s.log_n = s.log_n + 16'h0001;
        end
        if (last_idx) begin
          if (s.slv == BCAST_ADDR) begin // see R7, R14
            next_s.st = ST_RX;
          end else begin
            next_s.tb = {s.nreg[7:0], s.nreg[15:8], s.sa[7:0],
                         s.sa[15:8], s.fn, s.slv}; // see R6
            next_s = start_tx(next_s, RSP_LEN_FULL);
          end
        end else begin
          next_s.idx = s.idx + 7'h01;
          next_s.raddr = s.raddr + 16'h0001; // see R5
          next_s.rdata = mem[s.idx + 7'h01];
        end
      end
      ST_TX: begin
        // payload bytes feed the crc, then low and high check bytes
        if (tx_ready) begin
          next_s.ti = s.ti + 3'h1;
          if (s.ti < s.tlen - 3'h1) begin
            next_s.crc = crc_step;
            next_s.tx_data = s.tb[s.ti + 3'h1];
          end else if (s.ti == s.tlen - 3'h1) begin
            next_s.crc = crc_step;
            next_s.tx_data = crc_step[7:0]; // see R15, R22
          end else if (s.ti == s.tlen) begin
            next_s.tx_data = s.crc[15:8];
          end else begin
            next_s.st = ST_RX;
            next_s.crc = CRC_INIT;
          end
        end
      end
      default: begin
        next_s.st = ST_RX;
      end
    endcase
    // bytes arriving while busy taint the frame until its end
    if (s.st != ST_RX) begin
      if (rx_end) begin
        next_s.dirty = 1'b0;
      end else if (rx_valid) begin
        next_s.dirty = 1'b1; // see R13
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s <= '0;
      s.st <= ST_RX;
      s.crc <= CRC_INIT;
    end else begin
      s <= next_s;
    end
  end

  // word buffer; written as each low byte arrives, before the crc of the frame is checked
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_frame_end;
    rx_end && s.st == ST_RX && !s.dirty;
  endsequence
  sequence s_plain_hit;
    s_frame_end ##0 frame_ok && s.slv == my_addr
      && s.fn != FN_WRITE_MULTI && s.fn != FN_ACCESS_LOG;
  endsequence

  a_bad_frame_quiet: assert property ( // see R13
    s_frame_end ##0 !frame_ok |=> s.st == ST_RX)
    else $error("reply started for a faulty frame");
  a_foreign_quiet: assert property ( // see R23
    s_frame_end ##0 s.slv != my_addr && s.slv != BCAST_ADDR
      |=> s.st == ST_RX)
    else $error("reply started for another slave");
  a_bcast_no_tx: assert property ( // see R14
    s.st == ST_TX |-> s.tb[0] != BCAST_ADDR)
    else $error("reply sent to broadcast");
  a_exc_unsup_code: assert property ( // see R16
    s_plain_hit |=> s.st == ST_TX && s.tb[2] == EXC_FUNC
      && s.tb[1] == ($past(s.fn) | EXC_FLAG))
    else $error("wrong reply to unsupported function");
  a_log_zero_other: assert property ( // see R9
    s_plain_hit |=> s.log_a == 16'h0000 && s.log_n == 16'h0000)
    else $error("log not cleared by other function");
  a_write_gated: assert property ( // see R18, R21
    reg_wr |-> reg_present && reg_writable && reg_value_ok
      && s.st == ST_WRITE)
    else $error("write strobe on inaccessible register");
  a_write_ascend: assert property ( // see R5
    s.st == ST_WRITE ##1 s.st == ST_WRITE
      |-> reg_addr == $past(reg_addr) + 16'h0001)
    else $error("register addresses not ascending");
  a_write_reply: assert property ( // see R6
    s.st == ST_WRITE ##1 s.st == ST_TX |-> s.tlen == RSP_LEN_FULL
      && s.tb[1] == FN_WRITE_MULTI && {s.tb[2], s.tb[3]} == s.sa
      && {s.tb[4], s.tb[5]} == s.nreg)
    else $error("write reply does not echo the query");
  a_crc_low_first: assert property ( // see R22
    s.st == ST_TX && s.ti == s.tlen |-> s.tx_data == s.crc[7:0])
    else $error("check low byte not sent after payload");

endmodule

// ---- tb/mswle_master.sv ----
// bus master model: sends query frames, takes reply bytes with stalls
`timescale 1ns/10ps
module mswle_master (
  // clock
  input wire logic ref_clk,
  // reply side handshake
  output logic tx_ready,
  // query side, one byte per pulse
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_end,
  output logic rx_err
);
  // idle lines at time zero
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_end = 1'b0;
    rx_err = 1'b0;
  end

  // random stalls, so replies are taken promptly and slowly
  always @(negedge ref_clk) begin
    tx_ready <= ($urandom_range(0, 2) != 0);
  end

  // bytes go out back to back, gap marker two cycles after the last byte
  task automatic send(input logic [7:0] q[$], input logic err);
    foreach (q[i]) begin
      @(negedge ref_clk);
      rx_data <= q[i];
      rx_valid <= 1'b1;
    end
    @(negedge ref_clk);
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;  // no stale byte left on the line
    @(negedge ref_clk);
    rx_end <= 1'b1;
    rx_err <= err;
    @(negedge ref_clk);
    rx_end <= 1'b0;
    rx_err <= 1'b0;
  endtask
endmodule

// ---- tb/modbus_slave_write_log_error_bench.sv ----
// self-checking bench for the slave function handler
`timescale 1ns/10ps
module modbus_slave_write_log_error_bench;
  import mswle_pkg::*;
  logic ref_clk, rst, rx_valid, rx_end, rx_err, reg_wr, tx_valid, tx_ready;
  logic [7:0] my_addr, rx_data, tx_data;
  logic [15:0] reg_addr, reg_wdata, log_st, log_n;
  logic reg_present, reg_writable, reg_value_ok;
  logic [7:0] e_q[$];
  logic [31:0] w_q[$];
  int errors, compares;

  mswle_top dut_u (.ref_clk(ref_clk), .rst(rst), .my_addr(my_addr),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_end(rx_end),
    .rx_err(rx_err), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_present(reg_present),
    .reg_writable(reg_writable), .reg_value_ok(reg_value_ok),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
  mswle_master master_u (.ref_clk(ref_clk), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_end(rx_end),
    .rx_err(rx_err));

  // register map: hole at 0100, nothing from 8000 up, 0005 read-only
  assign reg_present = (reg_addr < 16'h8000) && (reg_addr != 16'h0100);
  assign reg_writable = (reg_addr != 16'h0005);
  assign reg_value_ok = (reg_wdata != 16'hdead);

  // clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic fail(input string m);
    errors++;
    $display("Error at %0t: %s", $time, m);
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) fail($sformatf("reply %h, want %h", got, exp));
  endtask

  task automatic check_write(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) fail($sformatf("write %h, want %h", got, exp));
  endtask

  task automatic stop_test();
    if (errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // frame check kept apart from the design's own step logic
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++) begin
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
    end
    return c;
  endfunction

  // note a reply, check bytes low then high
  task automatic reply(input logic [7:0] q[$]);
    logic [15:0] c;
    c = crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    e_q = {e_q, q};
  endtask

  // send a query; bad flips the check so the frame must be dropped
  task automatic query(input logic [7:0] q[$], input logic err,
                       input logic bad);
    logic [15:0] c;
    c = crc16(q) ^ {bad, 15'h0000};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    master_u.send(q, err);
  endtask

  // wait for the scan and the reply to finish, bounded
  task automatic settle();
    int n;
    n = 0;
    repeat (270) @(negedge ref_clk);
    while ((e_q.size() != 0 || tx_valid !== 1'b0) && n < 4000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 4000) fail("reply did not finish");
  endtask

  // write query with n words; bad is the index of a refused value
  task automatic wr(input logic [7:0] sa, input logic [15:0] st,
                    input int n, input int bad);
    logic [7:0] q[$];
    logic [31:0] w[$];
    logic [15:0] d, a, ls;
    logic [7:0] ex;
    logic badw;
    int ok;
    q = {sa, 8'h10, st[15:8], st[7:0], 8'(n >> 8), 8'(n), 8'(2 * n)};
    ex = (n < 1 || n > 125) ? 8'h03 : 8'h00;
    ok = 0;
    badw = 1'b0;
    ls = 16'h0000;
    for (int i = 0; i < n; i++) begin
      d = (i == bad) ? 16'hdead : 16'($urandom_range(0, 16'hdeac));
      a = st + 16'(i);
      q.push_back(d[15:8]);
      q.push_back(d[7:0]);
      if (a < 16'h8000 && a != 16'h0100 && a != 16'h0005) begin
        if (ok == 0) ls = a;
        ok++;
        badw = badw | (d == 16'hdead);
        w.push_back({a, d});
      end
    end
    if (ex == 8'h00 && ok == 0) ex = 8'h02;
    if (ex == 8'h00 && badw) ex = 8'h03;
    if (ex == 8'h00) w_q = {w_q, w};
    if (sa != 8'h00) begin
      if (ex == 8'h00) begin
        reply(q[0:5]);
      end else begin
        reply({sa, 8'h90, ex});
      end
    end
    // the log follows a broadcast write as well
    log_st = (ex == 8'h00) ? ls : 16'h0000;
    log_n = (ex == 8'h00) ? 16'(ok) : 16'h0000;
    query(q, 1'b0, 1'b0);
    settle();
  endtask

  // access-log query; the log is cleared by it
  task automatic log_q(input logic wait_done);
    reply({my_addr, 8'h46, log_st[15:8], log_st[7:0], log_n[15:8],
           log_n[7:0]});
    log_st = 16'h0000;
    log_n = 16'h0000;
    query({my_addr, 8'h46}, 1'b0, 1'b0);
    if (wait_done) settle();
  endtask

  // compare each reply byte and register write with the oldest note
  always @(posedge ref_clk) begin
    if (!rst && tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (e_q.size() == 0) fail("unexpected reply byte");
      else check_byte(tx_data, e_q.pop_front());
    end
    if (!rst && reg_wr === 1'b1) begin
      if (w_q.size() == 0) fail("unexpected register write");
      else check_write({reg_addr, reg_wdata}, w_q.pop_front());
    end
  end

  // watchdog, well beyond the expected run length
  initial begin
    repeat (80000) @(posedge ref_clk);
    fail("watchdog expired");
    stop_test();
  end

  // main sequence
  initial begin
    void'($urandom(96285));
    errors = 0;
    compares = 0;
    log_st = 16'h0000;
    log_n = 16'h0000;
    rst = 1'b1;
    my_addr = 8'h19;
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    wr(my_addr, 16'h03ee, 2, -1);
    log_q(1'b1);
    log_q(1'b1);
    wr(my_addr, 16'h00ff, 3, -1);  // hole skipped
    log_q(1'b1);
    wr(my_addr, 16'h0004, 3, -1);  // read-only skipped
    log_q(1'b1);
    wr(my_addr, 16'h8000, 2, -1);
    wr(my_addr, 16'h0010, 3, 1);
    log_q(1'b1);
    wr(my_addr, 16'h0200, 125, -1);
    wr(my_addr, 16'h0200, 126, -1);
    wr(my_addr, 16'h0000, 0, -1);
    wr(8'h00, 16'h0020, 2, -1);
    reply({my_addr, 8'h83, 8'h01});
    query({my_addr, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0, 1'b0);
    settle();
    log_st = 16'h0000;
    log_n = 16'h0000;
    log_q(1'b1);
    // frames that must stay unanswered
    query({my_addr, 8'h46}, 1'b1, 1'b0);
    query({my_addr, 8'h46}, 1'b0, 1'b1);
    query({8'h22, 8'h46}, 1'b0, 1'b0);
    query({8'h00, 8'h46}, 1'b0, 1'b0);
    query({my_addr}, 1'b0, 1'b0);
    settle();
    // log query one byte too long is refused as bad data
    reply({my_addr, 8'hc6, 8'h03});
    query({my_addr, 8'h46, 8'h00}, 1'b0, 1'b0);
    settle();
    // second query lands while the first reply is going out
    log_q(1'b0);
    query({my_addr, 8'h46}, 1'b0, 1'b0);
    settle();
    // reset in mid-run empties the log
    wr(my_addr, 16'h0040, 2, -1);
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    log_st = 16'h0000;
    log_n = 16'h0000;
    log_q(1'b1);
    for (int k = 0; k < 4; k++) begin
      wr(my_addr, 16'($urandom_range(0, 16'h0110)),
         $urandom_range(1, 8), -1);
      log_q(1'b1);
    end
    if (e_q.size() != 0 || w_q.size() != 0) fail("notes left over");
    stop_test();
  end
endmodule
